// file: core/rvf_pkg.sv
// Package of register offsets, field positions, reset values and frame limits for the filter.
package rvf_pkg;

  localparam int          RVF_AW          = 6;
  localparam int          RVF_CNT_W       = 11;

  localparam logic [5:0]  RVF_OFS_CTRL    = 6'h00;
  localparam logic [5:0]  RVF_OFS_ADDR_LO = 6'h04;
  localparam logic [5:0]  RVF_OFS_ADDR_HI = 6'h08;
  localparam logic [5:0]  RVF_OFS_HASH_LO = 6'h0C;
  localparam logic [5:0]  RVF_OFS_HASH_HI = 6'h10;
  localparam logic [5:0]  RVF_OFS_VLAN_A  = 6'h14;
  localparam logic [5:0]  RVF_OFS_VLAN_B  = 6'h18;
  localparam logic [5:0]  RVF_OFS_STATUS  = 6'h1C;
  localparam logic [5:0]  RVF_OFS_ACC_CNT = 6'h20;
  localparam logic [5:0]  RVF_OFS_DRP_CNT = 6'h24;

  localparam int          RVF_BIT_HPF     = 0;
  localparam int          RVF_BIT_HO      = 1;
  localparam int          RVF_BIT_INV     = 2;
  localparam int          RVF_BIT_ALL     = 3;
  localparam int          RVF_BIT_MCPASS  = 4;
  localparam int          RVF_CTRL_W      = 5;

  localparam int          RVF_ST_ACC      = 0;
  localparam int          RVF_ST_VLAN     = 1;
  localparam int          RVF_ST_LONG     = 2;
  localparam int          RVF_ST_MCAST    = 3;
  localparam int          RVF_ST_IDX_LSB  = 8;

  localparam logic [4:0]  RVF_CTRL_RST    = 5'h00;
  localparam logic [15:0] RVF_VLAN_A_RST  = 16'h8100;
  localparam logic [15:0] RVF_VLAN_B_RST  = 16'h0000;

  localparam logic [10:0] RVF_MAX_LEN     = 11'd1518;
  localparam logic [10:0] RVF_MAX_LEN_TAG = 11'd1522;
  localparam logic [10:0] RVF_DA_BYTES    = 11'd6;
  localparam logic [10:0] RVF_TAG_HI_POS  = 11'd12;
  localparam logic [10:0] RVF_TAG_LO_POS  = 11'd13;

  localparam logic [31:0] RVF_CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] RVF_CRC_POLY    = 32'hEDB88320;
  localparam int          RVF_HASH_MSB    = 31;
  localparam int          RVF_HASH_LSB    = 26;

endpackage

// file: core/rvf_crc32.sv
// Byte-wide Ethernet CRC-32 engine with a registered result, used for hash indexing.
`timescale 1ns/10ps
module rvf_crc32
  import rvf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clear,
  input  wire logic        i_en,
  input  wire logic [7:0]  i_byte,
  output logic      [31:0] o_crc
);

  // Folds one byte into the reflected CRC, least significant bit first as on the wire.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ b[i])
        r = (r >> 1) ^ RVF_CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_crc <= RVF_CRC_INIT;
    else if (i_clear)
      o_crc <= RVF_CRC_INIT;
    else if (i_en)
      o_crc <= crc_byte(o_crc, i_byte);
  end

endmodule // rvf_crc32

// file: core/rvf_filter.sv
// Receive VLAN recognition, length limit and destination address filter with Avalon-MM registers.
//
// Summary of operation
// - Bytes 12 and 13 matching either tag register mark the frame VLAN-tagged.
// - Tag register A resets to 0x8100; tag register B is free for software.
// - Frames over 1518 bytes are dropped; tagged frames may reach 1522 bytes.
// - The first received bit of the destination flags multicast versus physical.
// - A frame failing the selected address filter is not accepted.
// - All controls clear: every destination must equal the station address.
// - Hash-perfect only: physical perfect-matched, multicast hash-filtered.
// - Hash-only with hash-perfect: physical and multicast both hash-filtered.
// - Inverse alone: accept destinations differing from station, reject equal ones.
// - Accept-all without inverse accepts every frame including broadcasts.
// - Pass-all-multicast accepts every multicast frame in any mode.
// - With pass-all-multicast, physical is perfect unless inverse, accept-all, or hash-only with hash-perfect is set.
// - Station address is address-high bits over address-low bits, 48 in all.
// - Destination runs through CRC logic; top six CRC bits index the hash.
// - Index MSB picks high or low hash word; five bits pick the bit.
`timescale 1ns/10ps
module rvf_filter
  import rvf_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic [RVF_AW-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_rx_valid,
  input  wire logic [7:0]        i_rx_data,
  input  wire logic              i_rx_last,
  output logic                   o_frm_done,
  output logic                   o_frm_accept,
  output logic                   o_frm_vlan,
  output logic                   o_frm_too_long,
  output logic                   o_frm_mcast
);

  typedef enum logic [1:0] {
    RVF_S_ADDR = 2'b01,
    RVF_S_BODY = 2'b10
  } rvf_state_t;

  rvf_state_t              state_q;
  logic [RVF_CTRL_W-1:0]   ctrl_q;
  logic [31:0]             addr_lo_q;
  logic [15:0]             addr_hi_q;
  logic [31:0]             hash_lo_q;
  logic [31:0]             hash_hi_q;
  logic [15:0]             vlan_a_q;
  logic [15:0]             vlan_b_q;
  logic [31:0]             status_q;
  logic [CNT_W-1:0]        acc_cnt_q;
  logic [CNT_W-1:0]        drp_cnt_q;
  logic                    ack_q;
  logic [RVF_CNT_W-1:0]    cnt_q;
  logic [47:0]             da_q;
  logic [7:0]              tag_hi_q;
  logic                    vlan_q;
  logic [31:0]             crc;
  logic                    req;
  logic                    wr_take;
  logic [RVF_CNT_W-1:0]    len;
  logic [5:0]              hash_idx;
  logic                    is_mcast;
  logic                    is_perfect;
  logic                    hash_hit;
  logic                    tag_match;
  logic                    frm_vlan;
  logic                    frm_long;
  logic                    frm_pass;

  // Merges bus write data into a register under the byte enables.
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Destination filter decision for one frame from the mode controls.
  function automatic logic filt_pass(input logic [RVF_CTRL_W-1:0] c, input logic mc,
                                     input logic perf, input logic hit);
    logic r;
    if (c[RVF_BIT_ALL] && !c[RVF_BIT_INV])
      r = 1'b1;
    else if (mc && c[RVF_BIT_MCPASS])
      r = 1'b1;
    else if (c[RVF_BIT_INV])
      r = !perf;
    else if (mc)
      r = c[RVF_BIT_HPF] ? hit : perf;
    else
      r = (c[RVF_BIT_HO] && c[RVF_BIT_HPF]) ? hit : perf;
    return r;
  endfunction

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_take           = i_avs_write & ack_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_avs_readdata <= 32'h00000000;
    else if (i_avs_read && !ack_q)
    begin
      case (i_avs_address)
        RVF_OFS_CTRL:    o_avs_readdata <= {{(32-RVF_CTRL_W){1'b0}}, ctrl_q};
        RVF_OFS_ADDR_LO: o_avs_readdata <= addr_lo_q;
        RVF_OFS_ADDR_HI: o_avs_readdata <= {16'h0000, addr_hi_q};
        RVF_OFS_HASH_LO: o_avs_readdata <= hash_lo_q;
        RVF_OFS_HASH_HI: o_avs_readdata <= hash_hi_q;
        RVF_OFS_VLAN_A:  o_avs_readdata <= {16'h0000, vlan_a_q};
        RVF_OFS_VLAN_B:  o_avs_readdata <= {16'h0000, vlan_b_q};
        RVF_OFS_STATUS:  o_avs_readdata <= status_q;
        RVF_OFS_ACC_CNT: o_avs_readdata <= 32'(acc_cnt_q);
        RVF_OFS_DRP_CNT: o_avs_readdata <= 32'(drp_cnt_q);
        default:         o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q    <= RVF_CTRL_RST;
      addr_lo_q <= 32'h00000000;
      addr_hi_q <= 16'h0000;
    end
    else if (wr_take)
    begin
      case (i_avs_address)
        RVF_OFS_CTRL:
          ctrl_q <= RVF_CTRL_W'(be_merge(32'(ctrl_q), i_avs_writedata, i_avs_byteenable));
        RVF_OFS_ADDR_LO:
          addr_lo_q <= be_merge(addr_lo_q, i_avs_writedata, i_avs_byteenable);
        RVF_OFS_ADDR_HI:
          addr_hi_q <= 16'(be_merge(32'(addr_hi_q), i_avs_writedata, i_avs_byteenable));
        default:
          ctrl_q <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hash_lo_q <= 32'h00000000;
      hash_hi_q <= 32'h00000000;
    end
    else if (wr_take)
    begin
      case (i_avs_address)
        RVF_OFS_HASH_LO:
          hash_lo_q <= be_merge(hash_lo_q, i_avs_writedata, i_avs_byteenable);
        RVF_OFS_HASH_HI:
          hash_hi_q <= be_merge(hash_hi_q, i_avs_writedata, i_avs_byteenable);
        default:
          hash_lo_q <= hash_lo_q;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vlan_a_q  <= RVF_VLAN_A_RST;
      vlan_b_q  <= RVF_VLAN_B_RST;
    end
    else if (wr_take)
    begin
      case (i_avs_address)
        RVF_OFS_VLAN_A:
          vlan_a_q <= 16'(be_merge(32'(vlan_a_q), i_avs_writedata, i_avs_byteenable));
        RVF_OFS_VLAN_B:
          vlan_b_q <= 16'(be_merge(32'(vlan_b_q), i_avs_writedata, i_avs_byteenable));
        default:
          vlan_a_q <= vlan_a_q;
      endcase
    end
  end

  // Destination CRC covers exactly the six address bytes of each frame.
  rvf_crc32 u_crc (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_clear (i_rx_valid & i_rx_last),
    .i_en    (i_rx_valid & (state_q == RVF_S_ADDR)),
    .i_byte  (i_rx_data),
    .o_crc   (crc)
  );

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= RVF_S_ADDR;
    else if (i_rx_valid)
    begin
      case (state_q)
        RVF_S_ADDR:
          if (i_rx_last)
            state_q <= RVF_S_ADDR;
          else if (cnt_q == RVF_DA_BYTES - 11'd1)
            state_q <= RVF_S_BODY;
        RVF_S_BODY:
          if (i_rx_last)
            state_q <= RVF_S_ADDR;
        default:
          state_q <= RVF_S_ADDR;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_q <= '0;
    else if (i_rx_valid && i_rx_last)
      cnt_q <= '0;
    else if (i_rx_valid && (cnt_q != '1))
      cnt_q <= cnt_q + 11'd1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      da_q <= '0;
    else if (i_rx_valid && (state_q == RVF_S_ADDR))
      da_q[8*cnt_q[2:0] +: 8] <= i_rx_data;
  end

  assign tag_match = ({tag_hi_q, i_rx_data} == vlan_a_q) ||
                     ({tag_hi_q, i_rx_data} == vlan_b_q);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tag_hi_q <= 8'h00;
      vlan_q   <= 1'b0;
    end
    else if (i_rx_valid)
    begin
      if (i_rx_last)
        vlan_q <= 1'b0;
      else if (cnt_q == RVF_TAG_LO_POS)
        vlan_q <= tag_match;
      if (cnt_q == RVF_TAG_HI_POS)
        tag_hi_q <= i_rx_data;
    end
  end

  assign len        = (cnt_q == '1) ? cnt_q : cnt_q + 11'd1;
  assign frm_vlan   = vlan_q || ((cnt_q == RVF_TAG_LO_POS) && tag_match);
  assign frm_long   = len > (frm_vlan ? RVF_MAX_LEN_TAG : RVF_MAX_LEN);
  assign is_mcast   = da_q[0];
  assign is_perfect = (da_q == {addr_hi_q, addr_lo_q});
  assign hash_idx   = crc[RVF_HASH_MSB:RVF_HASH_LSB];
  assign hash_hit   = hash_idx[5] ? hash_hi_q[hash_idx[4:0]]
                                  : hash_lo_q[hash_idx[4:0]];
  assign frm_pass   = filt_pass(ctrl_q, is_mcast, is_perfect, hash_hit);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_frm_done <= 1'b0;
    else
      o_frm_done <= i_rx_valid & i_rx_last;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_frm_accept   <= 1'b0;
      o_frm_vlan     <= 1'b0;
      o_frm_too_long <= 1'b0;
      o_frm_mcast    <= 1'b0;
    end
    else if (i_rx_valid && i_rx_last)
    begin
      o_frm_accept   <= frm_pass & ~frm_long;
      o_frm_vlan     <= frm_vlan;
      o_frm_too_long <= frm_long;
      o_frm_mcast    <= is_mcast;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status_q <= 32'h00000000;
    else if (i_rx_valid && i_rx_last)
    begin
      status_q                              <= 32'h00000000;
      status_q[RVF_ST_ACC]                  <= frm_pass & ~frm_long;
      status_q[RVF_ST_VLAN]                 <= frm_vlan;
      status_q[RVF_ST_LONG]                 <= frm_long;
      status_q[RVF_ST_MCAST]                <= is_mcast;
      status_q[RVF_ST_IDX_LSB +: 6]         <= hash_idx;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      acc_cnt_q <= '0;
    else if (i_rx_valid && i_rx_last && frm_pass && !frm_long)
      acc_cnt_q <= acc_cnt_q + CNT_W'(1);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      drp_cnt_q <= '0;
    else if (i_rx_valid && i_rx_last && !(frm_pass && !frm_long))
      drp_cnt_q <= drp_cnt_q + CNT_W'(1);
  end

endmodule // rvf_filter

// file: tb/rvf_phy_model.sv
// Receive stream source standing in for the PHY side.
`timescale 1ns/10ps
module rvf_phy_model
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_go,
  input  wire logic [47:0] i_da,
  input  wire logic [15:0] i_tag,
  input  wire logic [11:0] i_len,
  input  wire logic        i_slow,
  output logic             o_rx_valid,
  output logic      [7:0]  o_rx_data,
  output logic             o_rx_last
);
  logic [11:0] idx_q;
  logic        busy_q;
  logic        ph_q;

  function automatic logic [7:0] byte_at(input logic [11:0] k);
    if (k < 12'h006)
      return i_da[8*k +: 8];
    if (k == 12'h00C)
      return i_tag[15:8];
    if (k == 12'h00D)
      return i_tag[7:0];
    return k[7:0] ^ 8'h5A;
  endfunction

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {o_rx_valid, o_rx_last, o_rx_data, busy_q, idx_q, ph_q} <= '0;
    end
    else
    begin
      ph_q <= ~ph_q;
      if (i_go)
      begin
        {busy_q, idx_q, o_rx_valid, o_rx_last} <= {1'b1, 12'h000, 2'b00};
      end
      else if (busy_q && (!i_slow || ph_q))
      begin
        o_rx_valid <= 1'b1;
        o_rx_data  <= byte_at(idx_q);
        o_rx_last  <= (idx_q == i_len - 12'h001);
        busy_q     <= (idx_q != i_len - 12'h001);
        idx_q      <= idx_q + 12'h001;
      end
      else
      begin
        {o_rx_valid, o_rx_last} <= 2'b00;
        o_rx_data <= ~o_rx_data;
      end
    end
  end
endmodule // rvf_phy_model

// file: tb/rvf_filter_checker.sv
// Concurrent checks on the ports of the receive filter.
`timescale 1ns/10ps
module rvf_filter_checker
  import rvf_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic [RVF_AW-1:0] i_avs_address,
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic [31:0]       i_avs_writedata,
  input wire logic [3:0]        i_avs_byteenable,
  input wire logic              o_avs_waitrequest,
  input wire logic              i_rx_valid,
  input wire logic [7:0]        i_rx_data,
  input wire logic              i_rx_last,
  input wire logic              o_frm_done,
  input wire logic              o_frm_accept,
  input wire logic              o_frm_vlan,
  input wire logic              o_frm_too_long,
  input wire logic              o_frm_mcast
);
  logic [11:0] cnt_q;
  logic [11:0] len_q;
  logic        mc_q;
  logic [4:0]  ctrl_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {cnt_q, len_q, mc_q} <= '0;
    else if (i_rx_valid)
    begin
      cnt_q <= i_rx_last ? 12'h000 : cnt_q + 12'h001;
      if (i_rx_last)
        len_q <= cnt_q + 12'h001;
      if (cnt_q == 12'h000)
        mc_q <= i_rx_data[0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ctrl_q <= RVF_CTRL_RST;
    else if (i_avs_write && !o_avs_waitrequest && i_avs_address == RVF_OFS_CTRL
             && i_avs_byteenable[0])
      ctrl_q <= i_avs_writedata[4:0];
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_frm_end; i_rx_valid && i_rx_last; endsequence
  sequence s_req_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence

  AST_BUS_WAIT: assert property (s_req_wait |=> !o_avs_waitrequest) else $error("wait");
  AST_DONE: assert property (s_frm_end |=> o_frm_done) else $error("done late");
  AST_DONE_CAUSE: assert property (o_frm_done |-> $past(i_rx_valid && i_rx_last))
    else $error("done stray");
  AST_MCAST: assert property (o_frm_done |-> o_frm_mcast == mc_q) else $error("mcast");
  AST_LEN: assert property (o_frm_done |-> o_frm_too_long ==
    (len_q > (o_frm_vlan ? RVF_MAX_LEN_TAG : RVF_MAX_LEN))) else $error("length");
  AST_LONG_DROP: assert property (o_frm_done && o_frm_too_long |-> !o_frm_accept)
    else $error("long accepted");
  AST_SHORT: assert property (o_frm_done && len_q < 12'd14 |-> !o_frm_vlan)
    else $error("short tagged");
  AST_HOLD: assert property (!o_frm_done |-> $stable(o_frm_accept)) else $error("hold");
  AST_PROMISC: assert property (o_frm_done && ctrl_q[RVF_BIT_ALL] && !ctrl_q[RVF_BIT_INV]
    && !o_frm_too_long |-> o_frm_accept) else $error("promisc");
  AST_MCPASS: assert property (o_frm_done && ctrl_q[RVF_BIT_MCPASS] && o_frm_mcast
    && !o_frm_too_long |-> o_frm_accept) else $error("mcpass");
endmodule // rvf_filter_checker

bind rvf_filter rvf_filter_checker rvf_filter_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_waitrequest(o_avs_waitrequest), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
  .i_rx_last(i_rx_last), .o_frm_done(o_frm_done), .o_frm_accept(o_frm_accept),
  .o_frm_vlan(o_frm_vlan), .o_frm_too_long(o_frm_too_long), .o_frm_mcast(o_frm_mcast));

// file: tb/rvf_filter_tb.sv
// Self-checking testbench of the receive filter.
`timescale 1ns/10ps
module rvf_filter_tb
  import rvf_pkg::*;
;
  logic        i_clk, i_rst_n, rd, wr, go, slow, vl, lg, ex;
  logic [5:0]  adr;
  logic [31:0] wd, be_d, d, acc_n;
  logic [3:0]  be;
  logic [47:0] gda, sta, da;
  logic [15:0] gtg, vb, r, tg;
  logic [11:0] gln, ln;
  logic [63:0] hsh;
  logic [4:0]  c;
  logic        rxv, rxl, o_done, o_acc, o_vl, o_lg, o_mc, wt;
  logic [7:0]  rxd;
  logic [31:0] rdd;
  logic [15:0] lfsr = 16'hF0A7;
  int          error_cnt = 0;
  int          checks_done = 0;

  rvf_filter rvf_filter_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdd), .o_avs_waitrequest(wt), .i_rx_valid(rxv), .i_rx_data(rxd),
    .i_rx_last(rxl), .o_frm_done(o_done), .o_frm_accept(o_acc), .o_frm_vlan(o_vl),
    .o_frm_too_long(o_lg), .o_frm_mcast(o_mc));
  rvf_phy_model rvf_phy_model_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_da(gda),
    .i_tag(gtg), .i_len(gln), .i_slow(slow), .o_rx_valid(rxv), .o_rx_data(rxd),
    .o_rx_last(rxl));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] q = RVF_CRC_INIT;
    for (int i = 0; i < 48; i++)
      q = (q[0] ^ a[i]) ? (q >> 1) ^ RVF_CRC_POLY : q >> 1;
    return q[31:26];
  endfunction

  function automatic logic exp_acc(input logic [4:0] m, input logic [47:0] a, input logic l);
    logic pf = (a === sta);
    logic ht = hsh[hidx(a)];
    logic f;
    if (m[RVF_BIT_ALL] && !m[RVF_BIT_INV]) f = 1'b1;
    else if (m[RVF_BIT_MCPASS] && a[0]) f = 1'b1;
    else if (m[RVF_BIT_INV]) f = !pf;
    else if (m[RVF_BIT_HO] && m[RVF_BIT_HPF]) f = ht;
    else if (m[RVF_BIT_HPF] && a[0]) f = ht;
    else f = pf;
    return f && !l;
  endfunction

  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] v);
    @(posedge i_clk);
    adr <= a;
    wd  <= v;
    wr  <= w;
    rd  <= !w;
    do @(posedge i_clk); while (wt !== 1'b0);
    d = rdd;
    {rd, wr} <= 2'b00;
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  initial
  begin
    repeat (99000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    {i_rst_n, rd, wr, go, slow, adr, wd, gda, gtg, gln, acc_n} = '0;
    be = 4'hF;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (be_d[i])
    begin
      if (i < 5)
      begin
        bus(6'(i * 4 + 16'h14) & 6'h3F, 1'b0, 32'h0);
        chk32("reset_val", (i == 0) ? 32'h8100 : 32'h0, d);
      end
    end
    bus(RVF_OFS_CTRL, 1'b0, 32'h0);
    chk32("ctrl_reset", 32'h0, d);
    sta = {rnd(), rnd(), rnd()};
    hsh = {rnd(), rnd(), rnd(), rnd()};
    vb  = rnd() | 16'h0001;
    bus(RVF_OFS_ADDR_LO, 1'b1, sta[31:0]);
    bus(RVF_OFS_ADDR_HI, 1'b1, {16'h0, sta[47:32]});
    bus(RVF_OFS_HASH_LO, 1'b1, hsh[31:0]);
    bus(RVF_OFS_HASH_HI, 1'b1, hsh[63:32]);
    bus(RVF_OFS_VLAN_B, 1'b1, {16'h0, vb});
    for (int i = 0; i < 64; i++)
    begin
      r  = rnd();
      c  = (i < 32) ? 5'(i) : r[4:0];
      r  = rnd();
      da = (r[1:0] == 2'h0) ? sta : (r[1:0] == 2'h1) ? sta ^ 48'h1 :
           (r[1:0] == 2'h2) ? 48'hFFFFFFFFFFFF : {rnd(), rnd(), rnd()};
      ln = (r[4:2] < 3'h2) ? 12'd13 + r[4:2] : (r[4:2] < 3'h4) ? 12'd64 :
           (r[4:2] == 3'h4) ? 12'd1518 : (r[4:2] == 3'h5) ? 12'd1519 : 12'd1517 + r[4:2];
      tg = r[6:5] == 2'h0 ? 16'h8100 : r[6:5] == 2'h1 ? vb : 16'h0800;
      bus(RVF_OFS_CTRL, 1'b1, {27'h0, c});
      @(posedge i_clk);
      {gda, gtg, gln, slow, go} <= {da, tg, ln, r[7] && ln < 12'd100, 1'b1};
      @(posedge i_clk);
      go <= 1'b0;
      for (int n = 0; n < 4000 && o_done !== 1'b1; n++) @(negedge i_clk);
      vl = ln >= 12'd14 && (tg == 16'h8100 || tg == vb);
      lg = ln > (vl ? 12'd1522 : 12'd1518);
      ex = exp_acc(c, da, lg);
      acc_n += {31'h0, ex};
      chk1("done", 1'b1, o_done);
      chk1("vlan", vl, o_vl);
      chk1("too_long", lg, o_lg);
      chk1("mcast", da[0], o_mc);
      chk1("accept", ex, o_acc);
      bus(RVF_OFS_STATUS, 1'b0, 32'h0);
      chk32("hash_idx", {26'h0, hidx(da)}, {26'h0, d[13:8]});
    end
    bus(RVF_OFS_ACC_CNT, 1'b0, 32'h0);
    chk32("acc_cnt", acc_n, {16'h0, d[15:0]});
    bus(RVF_OFS_DRP_CNT, 1'b0, 32'h0);
    chk32("drp_cnt", 32'd64 - acc_n, {16'h0, d[15:0]});
    finish_test();
  end
endmodule // rvf_filter_tb
